//--- logic/svm_ctrl.sv
// supply voltage monitor control with wishbone slave and event status
//
// Design decisions made here: the Wishbone slave port and the address map.
`default_nettype none
module svm_ctrl #(
  parameter int unsigned FILTER_CYCLES = svm_pkg::FILTER_CYC
) (
  // clock and reset
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  input  wire logic                ce_i,
  // wishbone slave
  input  wire logic                cyc_i,
  input  wire logic                stb_i,
  input  wire logic                we_i,
  input  wire logic [svm_pkg::ADDR_W-1:0] adr_i,
  input  wire logic [3:0]          sel_i,
  input  wire logic [31:0]         dat_i,
  output logic      [31:0]         dat_o,
  output logic                     ack_o,
  // comparator side
  input  wire logic                below_i,
  output logic      [2:0]          threshold_code_o,
  output logic                     detector_en_o,
  // system side
  output logic                     reset_req_o,
  output logic                     undervoltage_irq_o,
  output logic                     irq_o
);
  import svm_pkg::*;

  localparam int unsigned CNT_W = $clog2(FILTER_CYCLES + 1);

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  function automatic logic code_valid(input logic [2:0] code);
    code_valid = (code >= CODE_MIN_VALID);
  endfunction : code_valid

  function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    lane_merge = r;
  endfunction : lane_merge

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [6:0]       ctrl;
  logic [6:0]       next_ctrl;
  logic [EVT_W-1:0] status;
  logic [EVT_W-1:0] next_status;
  logic [EVT_W-1:0] mask;
  logic [EVT_W-1:0] next_mask;
  logic             level;
  logic             next_level;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic             nmi;
  logic             next_nmi;
  logic             rreq;
  logic             next_rreq;
  logic [31:0]      rdata;
  logic [31:0]      next_rdata;
  logic             ack;
  logic             next_ack;

  logic             active;
  logic             fall_evt;
  logic             rise_evt;
  logic             irq_route;
  logic             wr_stb;
  logic [31:0]      ctrl_word;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  assign wr_stb = cyc_i && stb_i && we_i && !ack;
  assign ctrl_word = {24'h000000, level, ctrl};

  always_comb begin
    next_ack = cyc_i && stb_i && !ack;
    next_rdata = rdata;
    if (cyc_i && stb_i && !ack && !we_i) begin
      unique case (adr_i)
        CTRL_OFS: next_rdata = ctrl_word;
        STAT_OFS: next_rdata = {{(32-EVT_W){1'b0}}, status};
        MASK_OFS: next_rdata = {{(32-EVT_W){1'b0}}, mask};
        default:  next_rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata <= 32'h00000000;
      ack   <= 1'b0;
    end else if (ce_i) begin
      rdata <= next_rdata;
      ack   <= next_ack;
    end
  end

  // ----------------------------------------------------------------
  // control and mask registers
  // ----------------------------------------------------------------
  always_comb begin
    logic [31:0] m;
    m = 32'h00000000;
    next_ctrl = ctrl;
    next_mask = mask;
    if (wr_stb && adr_i == CTRL_OFS) begin
      m = lane_merge(ctrl_word, dat_i, sel_i);
      next_ctrl = m[6:0] & CTRL_WMASK[6:0];
    end
    if (wr_stb && adr_i == MASK_OFS) begin
      m = lane_merge({{(32-EVT_W){1'b0}}, mask}, dat_i, sel_i);
      next_mask = m[EVT_W-1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= CTRL_RESET[6:0];
      mask <= EVT_RESET;
    end else if (ce_i) begin
      ctrl <= next_ctrl;
      mask <= next_mask;
    end
  end

  // ----------------------------------------------------------------
  // comparator filter and routing
  // ----------------------------------------------------------------
  assign active = ctrl[ON_BIT] && code_valid(ctrl[3:1]);
  assign irq_route = !ctrl[RSTALW_BIT] && ctrl[IRQALW_BIT];

  always_comb begin
    next_level = level;
    next_cnt = '0;
    if (!active) begin
      next_level = 1'b0;
    end else if (below_i != level) begin
      if (cnt >= CNT_W'(FILTER_CYCLES - 1)) begin
        next_level = below_i;
      end else begin
        next_cnt = cnt + CNT_W'(1);
      end
    end
  end

  assign fall_evt = active && !level && next_level;
  assign rise_evt = active && level && !next_level;

  always_comb begin
    next_nmi = 1'b0;
    next_rreq = active && ctrl[RSTALW_BIT] && next_level;
    if (irq_route) begin
      next_nmi = fall_evt || (ctrl[EDGE_BIT] && rise_evt);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      level <= 1'b0;
      cnt   <= '0;
      nmi   <= 1'b0;
      rreq  <= 1'b0;
    end else if (ce_i) begin
      level <= next_level;
      cnt   <= next_cnt;
      nmi   <= next_nmi;
      rreq  <= next_rreq;
    end
  end

  // ----------------------------------------------------------------
  // sticky status, set wins over clear
  // ----------------------------------------------------------------
  always_comb begin
    logic [EVT_W-1:0] clr;
    clr = '0;
    if (wr_stb && adr_i == STAT_OFS && sel_i[0]) begin
      clr = dat_i[EVT_W-1:0];
    end
    next_status = (status & ~clr)
                | {next_rreq && !rreq, next_nmi && rise_evt,
                   next_nmi && fall_evt};
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status <= EVT_RESET;
    end else if (ce_i) begin
      status <= next_status;
    end
  end

  assign dat_o = rdata;
  assign ack_o = ack;
  assign threshold_code_o = ctrl[3:1];
  assign detector_en_o = active;
  assign reset_req_o = rreq;
  assign undervoltage_irq_o = nmi;
  assign irq_o = |(status & mask);

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  flag_tracks_level_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    ack && ($past(adr_i) == CTRL_OFS) && !$past(we_i) && $past(ce_i)
      |-> dat_o[7] == $past(level))
    else $error("level flag read mismatch");

  off_no_output_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    $past(!active) && $past(ce_i) |-> !reset_req_o && !undervoltage_irq_o)
    else $error("output while detector off");

  level_off_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    $past(!active) && $past(ce_i) |-> !level)
    else $error("level flag set while detector off");

  code_passed_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    $past(ce_i) && $past(wr_stb) && ($past(adr_i) == CTRL_OFS)
      && $past(sel_i[0]) && !$past(rst_i)
      |-> threshold_code_o == $past(dat_i[3:1]))
    else $error("threshold code mismatch");

  ctrl_write_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    $past(ce_i) && $past(wr_stb) && ($past(adr_i) == CTRL_OFS)
      && $past(sel_i[0]) && !$past(rst_i) |-> ctrl == $past(dat_i[6:0]))
    else $error("control write mismatch");

  reset_follows_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    ce_i && active && ctrl[RSTALW_BIT] && next_level |=> reset_req_o)
    else $error("reset request missing");

  reset_drop_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    ce_i && !next_level |=> !reset_req_o)
    else $error("reset request without low supply");

  stat_reset_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    ce_i && next_rreq && !rreq |=> status[2])
    else $error("reset event not recorded");

  fall_irq_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    ce_i && fall_evt && irq_route |=> undervoltage_irq_o)
    else $error("falling crossing irq missing");

  stat_fall_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    ce_i && fall_evt && irq_route |=> status[0])
    else $error("falling event not recorded");

  irq_blocked_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    $past(ctrl[RSTALW_BIT]) && $past(ce_i) |-> !undervoltage_irq_o)
    else $error("irq while reset routed");

  rise_irq_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    ce_i && rise_evt && irq_route && !ctrl[EDGE_BIT] |=> !undervoltage_irq_o)
    else $error("rise irq with falling-only");

  both_irq_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    ce_i && (rise_evt || fall_evt) && irq_route && ctrl[EDGE_BIT]
      |=> undervoltage_irq_o)
    else $error("missing crossing irq");

  stat_rise_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    ce_i && rise_evt && irq_route && ctrl[EDGE_BIT] |=> status[1])
    else $error("rising event not recorded");

  filter_hold_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    ce_i && active && (below_i != level) && cnt < CNT_W'(FILTER_CYCLES - 1)
      |=> level == $past(level))
    else $error("level changed before filter time");

  filter_fire_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    ce_i && active && (below_i != level) && cnt >= CNT_W'(FILTER_CYCLES - 1)
      |=> level == $past(below_i))
    else $error("level not taken after filter time");

  upper_zero_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    ack && $past(adr_i) == CTRL_OFS |-> dat_o[31:8] == 24'h000000)
    else $error("upper bits not zero");

  reset_clear_a: assert property (@(posedge clk_i)
    $past(rst_i) |-> ctrl == 7'h00 && !reset_req_o && !irq_o)
    else $error("control not cleared");

  // ----------------------------------------------------------------
  // covers
  // ----------------------------------------------------------------
  fall_irq_c: cover property (@(posedge clk_i) disable iff (rst_i)
    undervoltage_irq_o && level);
  rise_irq_c: cover property (@(posedge clk_i) disable iff (rst_i)
    undervoltage_irq_o && !level);
  reset_req_c: cover property (@(posedge clk_i) disable iff (rst_i)
    reset_req_o);
  masked_irq_c: cover property (@(posedge clk_i) disable iff (rst_i) irq_o);
  masked_nmi_c: cover property (@(posedge clk_i) disable iff (rst_i)
    undervoltage_irq_o && (mask == '0));
endmodule : svm_ctrl
`default_nettype wire

//--- logic/svm_pkg.sv
// package: register map, field positions and timing for the supply monitor
`default_nettype none
package svm_pkg;
  localparam int unsigned ADDR_W = 4;
  localparam logic [ADDR_W-1:0] CTRL_OFS = 4'h4;
  localparam logic [ADDR_W-1:0] STAT_OFS = 4'h8;
  localparam logic [ADDR_W-1:0] MASK_OFS = 4'hc;
  localparam int unsigned BELOW_BIT = 7;
  localparam int unsigned RSTALW_BIT = 6;
  localparam int unsigned IRQALW_BIT = 5;
  localparam int unsigned EDGE_BIT = 4;
  localparam int unsigned CODE_LSB = 1;
  localparam int unsigned ON_BIT = 0;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] CTRL_WMASK = 8'h7f;
  localparam logic [2:0] CODE_MIN_VALID = 3'h3;
  // status bits: 0 falling crossing, 1 rising crossing, 2 reset request
  localparam int unsigned EVT_W = 3;
  localparam logic [EVT_W-1:0] EVT_RESET = 3'h0;
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned FILTER_US = 100;
  localparam int unsigned FILTER_CYC = FILTER_US * CLK_MHZ;
endpackage : svm_pkg
`default_nettype wire

//--- tb/svm_cmp_model.sv
// behavioural model of the analog supply comparator
`default_nettype none
module svm_cmp_model (
  // supply in tenths of a volt, threshold code
  input  wire logic [5:0] supply_i,
  input  wire logic [2:0] threshold_code_i,
  // comparator result
  output logic            below_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // code 3 is 2.5 V, 0.1 V a step; equal counts as below, no hysteresis
  assign below_o = (supply_i <= 6'(22 + threshold_code_i));
endmodule : svm_cmp_model
`default_nettype wire

//--- tb/svm_ctrl_tb.sv
// self-checking bench for the supply monitor control block
`default_nettype none
module svm_ctrl_tb;
  import svm_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int F = 8;
  logic              clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, below_i;
  logic              ce_i;
  logic [ADDR_W-1:0] adr_i;
  logic [3:0]        sel_i;
  logic [31:0]       dat_i, dat_o;
  logic [2:0]        threshold_code_o;
  logic              detector_en_o, reset_req_o, undervoltage_irq_o, irq_o;
  logic [5:0]        supply;
  int                error_cnt, cmp_count, pulses, p0, cyc_cnt;
  logic [31:0]       cv[3] = '{32'h27, 32'h37, 32'h77};
  int                np[3] = '{1, 2, 0};
  logic [31:0]       sx[3] = '{32'h1, 32'h3, 32'h4};
  logic [31:0]       rx[3] = '{32'h0, 32'h0, 32'h1};
  logic [31:0]       r2[2] = '{32'h65, 32'h66};

  svm_ctrl #(.FILTER_CYCLES(F)) u_svm_ctrl (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
    .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .below_i(below_i),
    .threshold_code_o(threshold_code_o), .detector_en_o(detector_en_o),
    .reset_req_o(reset_req_o), .undervoltage_irq_o(undervoltage_irq_o),
    .irq_o(irq_o));
  svm_cmp_model u_svm_cmp_model (.supply_i(supply),
    .threshold_code_i(threshold_code_o), .below_o(below_i));

  // ----------------------------------------
  // clock, timeout, event counter
  // ----------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    if (undervoltage_irq_o === 1'b1) pulses <= pulses + 1;
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 5000) begin
      error_cnt++;
      report_and_stop();
    end
  end

  // ----------------------------------------
  // bus and compare tasks
  // ----------------------------------------
  task automatic report_and_stop();
    if (error_cnt == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wb(logic w, logic [ADDR_W-1:0] a, logic [31:0] d,
                    output logic [31:0] q);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= 4'hf;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  task automatic wr(logic [ADDR_W-1:0] a, logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask : wr
  task automatic rdc(string nm, logic [ADDR_W-1:0] a, logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(nm, e, q);
  endtask : rdc
  task automatic settle(logic [5:0] v);
    supply <= v;
    repeat (F + 4) @(posedge clk_i);
  endtask : settle

  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial begin
    {rst_i, cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} = '0;
    rst_i = 1'b1;
    ce_i = 1'b1;
    supply = 6'd33;
    {error_cnt, cmp_count, pulses, cyc_cnt} = '0;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rdc("ctrl_rst", CTRL_OFS, 32'h0);
    rdc("stat_rst", STAT_OFS, 32'h0);
    rdc("mask_rst", MASK_OFS, 32'h0);
    wr(4'h0, 32'hffffffff);
    rdc("unmapped", 4'h0, 32'h0);
    wr(CTRL_OFS, 32'hffffffff);
    rdc("ctrl_ro", CTRL_OFS, 32'h7f);
    chk("code_o", 32'h7, 32'(threshold_code_o));
    chk("en_o", 32'h1, 32'(detector_en_o));
    // reserved code, then detector off: nothing may happen
    foreach (r2[i]) begin
      wr(CTRL_OFS, r2[i]);
      p0 = pulses;
      settle(6'd20);
      chk("en_off", 32'h0, 32'(detector_en_o));
      chk("rst_off", 32'h0, 32'(reset_req_o));
      chk("irq_off", 32'h0, 32'(pulses - p0));
      settle(6'd33);
    end
    wr(MASK_OFS, 32'h7);
    // routing and edge choice; supply equal to 2.5 V counts as below
    foreach (cv[i]) begin
      wr(CTRL_OFS, cv[i]);
      p0 = pulses;
      settle(6'd25);
      chk("rst_req", rx[i], 32'(reset_req_o));
      rdc("ctrl_low", CTRL_OFS, cv[i] | 32'h80);
      settle(6'd26);
      chk("rst_rel", 32'h0, 32'(reset_req_o));
      chk("pulses", 32'(np[i]), 32'(pulses - p0));
      rdc("status", STAT_OFS, sx[i]);
      chk("irq_lvl", 32'h1, 32'(irq_o));
      wr(STAT_OFS, 32'h7);
      rdc("stat_clr", STAT_OFS, 32'h0);
      chk("irq_clr", 32'h0, 32'(irq_o));
    end
    // masked status still leaves the dedicated line pulsing
    wr(MASK_OFS, 32'h0);
    wr(CTRL_OFS, 32'h27);
    p0 = pulses;
    settle(6'd20);
    chk("nmi", 32'h1, 32'(pulses - p0));
    chk("irq_mask", 32'h0, 32'(irq_o));
    wr(MASK_OFS, 32'h1);
    chk("irq_unmask", 32'h1, 32'(irq_o));
    wr(STAT_OFS, 32'h1);
    chk("irq_w1c", 32'h0, 32'(irq_o));
    settle(6'd33);
    // dip shorter than the filter
    p0 = pulses;
    supply <= 6'd20;
    repeat (F - 2) @(posedge clk_i);
    settle(6'd33);
    chk("glitch", 32'h0, 32'(pulses - p0));
    // clock enable low freezes the filter, high lets it run on
    ce_i <= 1'b0;
    p0 = pulses;
    settle(6'd20);
    chk("ce_frz", 32'h0, 32'(pulses - p0));
    ce_i <= 1'b1;
    settle(6'd20);
    chk("ce_run", 32'h1, 32'(pulses - p0));
    settle(6'd33);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rdc("ctrl_rst2", CTRL_OFS, 32'h0);
    chk("rst2_en", 32'h0, 32'(detector_en_o));
    report_and_stop();
  end
endmodule : svm_ctrl_tb
`default_nettype wire
